// [bench/pcg_clock_gating_props.sv]
/* Port checker of the clock gating block.
   Assumes it is bound to pcg_clock_gating and sees its ports only. */
`timescale 1ns/1ps
module pcg_clock_gating_props #(
   parameter logic [pcg_pkg::PCG_GATE_W-1:0] PER_MASK =
      pcg_pkg::PCG_PER_MASK
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic SYS_RST,
   // Bus and core handshake.
   input wire pcg_pkg::pcg_apb_req_t APB_REQ,
   input wire pcg_pkg::pcg_apb_rsp_t APB_RSP,
   input wire pcg_pkg::pcg_core_in_t CORE_IN,
   // Gate state.
   input wire logic CORE_CLK_ON,
   input wire logic CORE_STOP_PENDING,
   input wire logic [pcg_pkg::PCG_GATE_W-1:0] PERIPH_CLK_ON
);
   import pcg_pkg::*;
   logic acc;
   logic wr;
   logic [5:0] wa;
   assign acc = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready;
   assign wr = acc & APB_REQ.pwrite;
   assign wa = APB_REQ.paddr[7:2];
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_per_set;
      wr && wa == 6'h04 |=> PERIPH_CLK_ON ==
         ($past(PERIPH_CLK_ON) | ($past(APB_REQ.pwdata[14:0]) & PER_MASK));
   endproperty
   a_per_set: assert property (p_per_set)
      else $error("enable write gave wrong gates");
   property p_per_clr;
      wr && wa == 6'h05 |=> PERIPH_CLK_ON ==
         ($past(PERIPH_CLK_ON) & ~$past(APB_REQ.pwdata[14:0]));
   endproperty
   a_per_clr: assert property (p_per_clr)
      else $error("disable write gave wrong gates");
   property p_per_hold;
      !(wr && (wa == 6'h04 || wa == 6'h05)) |=> $stable(PERIPH_CLK_ON);
   endproperty
   a_per_hold: assert property (p_per_hold)
      else $error("gates moved without a write");
   property p_ready;
      APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready ##1 !APB_RSP.pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready not a single access pulse");
   property p_rd_state;
      acc && !APB_REQ.pwrite && wa == 6'h06 |->
         APB_RSP.prdata == {17'h0, PERIPH_CLK_ON};
   endproperty
   a_rd_state: assert property (p_rd_state)
      else $error("state read differs from gates");
   property p_stop;
      CORE_STOP_PENDING && CORE_IN.instr_done |=>
         !CORE_CLK_ON && !CORE_STOP_PENDING;
   endproperty
   a_stop: assert property (p_stop)
      else $error("core did not halt at instruction end");
   property p_pend;
      wr && wa == 6'h01 && APB_REQ.pwdata[0] && CORE_CLK_ON &&
         !CORE_STOP_PENDING |=>
         CORE_STOP_PENDING && CORE_CLK_ON;
   endproperty
   a_pend: assert property (p_pend)
      else $error("stop request not held pending");
   property p_wake;
      !CORE_CLK_ON && !CORE_STOP_PENDING && CORE_IN.irq_pending |=>
         CORE_CLK_ON;
   endproperty
   a_wake: assert property (p_wake)
      else $error("interrupt did not restart core");
endmodule

// [bench/pcg_core_model.sv]
/* Behavioural core: ends an instruction every fourth cycle while its
   clock runs, and raises a pending interrupt when the bench asks.
   Assumes it shares CLK with the clock gating block. */
`timescale 1ns/1ps
module pcg_core_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control.
   input wire logic core_on,
   input wire logic wake,
   output pcg_pkg::pcg_core_in_t core_in
);
   import pcg_pkg::*;
   logic [1:0] cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
         core_in <= '0;
      end else begin
         // Instructions only advance on a running core clock.
         cnt_q <= core_on ? cnt_q + 2'h1 : cnt_q;
         core_in.instr_done <= core_on && cnt_q == 2'h3;
         core_in.irq_pending <= wake;
      end
   end
endmodule

// [bench/tb_pcg_clock_gating.sv]
/* Self-checking bench of the clock gating block over APB.
   Assumes the design, its package and the core model are compiled. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   mismatches++; $display("wrong value at %0t: got %h want %h", \
   $time, a, b); end end
module tb_pcg_clock_gating;
   import pcg_pkg::*;
   logic CLK = 0;
   logic SYS_RST = 1;
   logic wake = 0;
   pcg_apb_req_t req = '0;
   pcg_apb_rsp_t rsp;
   pcg_core_in_t cin;
   logic core_clk, core_on, pend;
   logic [PCG_GATE_W-1:0] per_clk, per_on;
   logic [31:0] rd;
   logic er;
   int mismatches = 0;
   int num_checks = 0;
   int n2 = 0;
   int n5 = 0;
   int nc = 0;
   int t;
   pcg_clock_gating i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .APB_REQ(req),
      .APB_RSP(rsp), .CORE_IN(cin), .CORE_CLK(core_clk),
      .PERIPH_CLK(per_clk), .CORE_CLK_ON(core_on),
      .CORE_STOP_PENDING(pend), .PERIPH_CLK_ON(per_on));
   pcg_core_model i_core (.clk(CLK), .rst(SYS_RST), .core_on(core_on),
      .wake(wake), .core_in(cin));
   initial begin
      forever #5 CLK = ~CLK;
   end
   always @(posedge per_clk[2]) n2++;
   always @(posedge per_clk[5]) n5++;
   always @(posedge core_clk) nc++;
   task automatic rw(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge CLK);
      req.penable <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic core_stop();
      rw(1'b1, PCG_OFS_SYS_DIS, 32'h1);
      t = 0;
      while (core_on !== 1'b0 && t < 20) begin
         @(posedge CLK);
         t++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge CLK);
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge CLK);
      SYS_RST <= 1'b0;
      rw(1'b0, PCG_OFS_SYS_STATE, 32'h0); `CHK(rd, 32'h1)
      rw(1'b0, PCG_OFS_PER_STATE, 32'h0); `CHK(rd, 32'h0)
      $display("reset test done");
      rw(1'b1, PCG_OFS_PER_EN, 32'hffff_ffff);
      rw(1'b0, PCG_OFS_PER_STATE, 32'h0); `CHK(rd, 32'h6ffc)
      rw(1'b0, PCG_OFS_PER_EN, 32'h0); `CHK(rd, 32'h0)
      rw(1'b1, PCG_OFS_PER_STATE, 32'h0);
      rw(1'b1, PCG_OFS_PER_DIS, 32'h24);
      rw(1'b0, PCG_OFS_PER_STATE, 32'h0); `CHK(rd, 32'h6fd8)
      rw(1'b1, PCG_OFS_PER_DIS, 32'h0);
      rw(1'b1, PCG_OFS_PER_EN, 32'h20);
      rw(1'b0, PCG_OFS_PER_STATE, 32'h0); `CHK(rd, 32'h6ff8)
      // Count on falling edges so no gated rising edge races the reset.
      @(negedge CLK);
      n2 = 0;
      n5 = 0;
      repeat (8) @(negedge CLK);
      `CHK(n2, 0)
      `CHK(n5, 8)
      rw(1'b0, 8'h0c, 32'h0); `CHK({er, rd}, 33'h1_0000_0000)
      $display("peripheral test done");
      core_stop(); `CHK(core_on, 1'b0)
      rw(1'b0, PCG_OFS_SYS_STATE, 32'h0); `CHK(rd, 32'h0)
      nc = 0;
      repeat (5) @(posedge CLK);
      `CHK(nc, 0)
      wake <= 1'b1;
      repeat (4) @(posedge CLK);
      wake <= 1'b0;
      `CHK(core_on, 1'b1)
      core_stop();
      rw(1'b1, PCG_OFS_SYS_EN, 32'h1);
      rw(1'b0, PCG_OFS_SYS_STATE, 32'h0); `CHK(rd, 32'h1)
      $display("core test done");
      wrap_up();
   end
endmodule
bind pcg_clock_gating pcg_clock_gating_props #(.PER_MASK(PER_MASK)) i_props (
   .CLK(CLK), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
   .CORE_IN(CORE_IN), .CORE_CLK_ON(CORE_CLK_ON),
   .CORE_STOP_PENDING(CORE_STOP_PENDING), .PERIPH_CLK_ON(PERIPH_CLK_ON));

// [core/pcg_clk_gate.sv]
/*
 * One glitch-free clock gate: a latch open while the clock is low holds
 * the enable, and an AND passes the clock.
 * Assumes the enable comes from a flip-flop on the rising edge of clk_in.
 */
`timescale 1ns/1ps

module pcg_clk_gate (
   // Clock in and out.
   input wire logic clk_in,
   output logic clk_out,
   // Gate control.
   input wire logic en
);

   logic en_l;

   // The enable can only change while the clock is low, so no phase of
   // the gated clock is ever shortened.
   always_latch begin
      if (!clk_in) begin
         en_l = en;
      end
   end

   assign clk_out = clk_in & en_l;

endmodule

// [core/pcg_clock_gating.sv]
/*
 * Core and peripheral clock gating block: an APB register slave that
 * starts and stops the processor core clock and each peripheral clock.
 * Assumes the core and the interrupt controller run from CLK (through the
 * core gate) so their handshake needs no synchroniser, and that APB is
 * clocked by CLK.
 */
// Notes on behaviour
// - One core clock; bit 0 of enable starts it, disable stops it.
// - After reset the core clock runs and its state register reads 0x1.
// - A pending enabled interrupt restarts a stopped core clock by itself.
// - A stop request waits for the current instruction to finish.
// - Stopping the core leaves the peripheral DMA channels clocked.
// - Writing 1 to a peripheral enable bit opens its gate; 0 does nothing.
// - Writing 1 to a peripheral disable bit closes its gate; 0 does nothing.
// - A disabled peripheral clock stops at once, without waiting.
// - A re-enabled peripheral resumes where it stopped; nothing is reset.
// - After reset all peripheral clocks are off; their state reads 0x0.
// - Gate bits share positions with the interrupt source bits.
// - Gates at bits 2-11, 13, 14; all other bits unused.
// - The peripheral state register reports each gate bit for bit.
// - Bit 0 of the core state register reports the core clock.
// - A peripheral state bit is 1 when enabled, 0 when disabled.
`timescale 1ns/1ps

module pcg_clock_gating #(
   parameter logic [pcg_pkg::PCG_GATE_W-1:0] PER_MASK =
      pcg_pkg::PCG_PER_MASK
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic SYS_RST,
   // Register bus.
   input wire pcg_pkg::pcg_apb_req_t APB_REQ,
   output pcg_pkg::pcg_apb_rsp_t APB_RSP,
   // Core and interrupt controller handshake.
   input wire pcg_pkg::pcg_core_in_t CORE_IN,
   // Gated clocks.
   output logic CORE_CLK,
   output logic [pcg_pkg::PCG_GATE_W-1:0] PERIPH_CLK,
   // Gate state.
   output logic CORE_CLK_ON,
   output logic CORE_STOP_PENDING,
   output logic [pcg_pkg::PCG_GATE_W-1:0] PERIPH_CLK_ON
);

   import pcg_pkg::*;

   // Bit 0 belongs to the core and bit 1 to no gate, so a mask using
   // them, or any bit not wired to a peripheral, cannot be served.
   if ((PER_MASK & ~PCG_PER_MASK) != '0) begin : g_bad_mask
      $error("PER_MASK names a bit with no peripheral clock");
   end

   // Bus state.
   logic ready_q;
   logic err_q;
   logic [PCG_DATA_W-1:0] rdata_q;

   // Gate state.
   pcg_core_state_t core_state_q;
   pcg_core_state_t core_state_d;
   logic core_on_q;
   logic core_on_d;
   logic [PCG_GATE_W-1:0] per_on_q;
   logic [PCG_GATE_W-1:0] per_on_d;

   // Decoded bus events.
   logic setup;
   logic access;
   logic wr;
   logic wr_sys_en;
   logic wr_sys_dis;
   logic wr_per_en;
   logic wr_per_dis;
   logic [PCG_GATE_W-1:0] per_set;
   logic [PCG_GATE_W-1:0] per_clr;

   // True when the word address falls on one of the six registers.
   function automatic logic is_mapped(input logic [PCG_ADDR_W-1:0] a);
      logic [PCG_ADDR_W-3:0] w;
      w = a[PCG_ADDR_W-1:2];
      return (w == PCG_OFS_SYS_EN[PCG_ADDR_W-1:2]) ||
             (w == PCG_OFS_SYS_DIS[PCG_ADDR_W-1:2]) ||
             (w == PCG_OFS_SYS_STATE[PCG_ADDR_W-1:2]) ||
             (w == PCG_OFS_PER_EN[PCG_ADDR_W-1:2]) ||
             (w == PCG_OFS_PER_DIS[PCG_ADDR_W-1:2]) ||
             (w == PCG_OFS_PER_STATE[PCG_ADDR_W-1:2]);
   endfunction

   // True when the word address matches one offset.
   function automatic logic at(input logic [PCG_ADDR_W-1:0] a,
                               input logic [PCG_ADDR_W-1:0] ofs);
      return a[PCG_ADDR_W-1:2] == ofs[PCG_ADDR_W-1:2];
   endfunction

   // Value returned by a read at the given address.
   function automatic logic [PCG_DATA_W-1:0] read_value(
      input logic [PCG_ADDR_W-1:0] a,
      input logic core_on,
      input logic [PCG_GATE_W-1:0] per_on
   );
      logic [PCG_DATA_W-1:0] v;
      v = '0;
      if (at(a, PCG_OFS_SYS_STATE)) begin
         // One means running, which agrees with the reset value.
         v[PCG_CORE_BIT] = core_on;
      end else if (at(a, PCG_OFS_PER_STATE)) begin
         // Unused positions stay zero.
         v[PCG_GATE_W-1:0] = per_on & PER_MASK;
      end
      // Enable and disable registers are write-only and read as zero.
      return v;
   endfunction

   // APB phases. The slave inserts no wait state: read data is loaded into
   // a flip-flop in the setup cycle, ready for the first access cycle.
   assign setup = APB_REQ.psel && !APB_REQ.penable;
   assign access = APB_REQ.psel && APB_REQ.penable && ready_q;
   assign wr = access && APB_REQ.pwrite && is_mapped(APB_REQ.paddr);

   assign wr_sys_en = wr && at(APB_REQ.paddr, PCG_OFS_SYS_EN);
   assign wr_sys_dis = wr && at(APB_REQ.paddr, PCG_OFS_SYS_DIS);
   assign wr_per_en = wr && at(APB_REQ.paddr, PCG_OFS_PER_EN);
   assign wr_per_dis = wr && at(APB_REQ.paddr, PCG_OFS_PER_DIS);

   // Only written ones act, and only on bits that have a gate.
   assign per_set = wr_per_en ?
      (APB_REQ.pwdata[PCG_GATE_W-1:0] & PER_MASK) : '0;
   assign per_clr = wr_per_dis ?
      (APB_REQ.pwdata[PCG_GATE_W-1:0] & PER_MASK) : '0;

   // Ready rises in the access phase that follows every setup cycle.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= setup;
      end
   end

   // Error and read data are settled in the setup cycle, so both stand
   // for the whole access phase. A gate that changes during that phase
   // is reported by the next read, not this one.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= !is_mapped(APB_REQ.paddr);
      end else if (access) begin
         err_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_q <= '0;
      end else if (setup && !APB_REQ.pwrite) begin
         rdata_q <= read_value(APB_REQ.paddr, core_on_q, per_on_q);
      end else if (access) begin
         rdata_q <= '0;
      end
   end

   assign APB_RSP.prdata = rdata_q;
   assign APB_RSP.pready = ready_q;
   assign APB_RSP.pslverr = err_q;

   // Core clock sequencing. A disable request only arms the stop; the
   // gate closes once the core reports the instruction boundary.
   always_comb begin
      core_state_d = core_state_q;
      unique case (core_state_q)
         PCG_CORE_RUN: begin
            if (wr_sys_dis && APB_REQ.pwdata[PCG_CORE_BIT]) begin
               core_state_d = PCG_CORE_STOPPING;
            end
         end
         PCG_CORE_STOPPING: begin
            if (wr_sys_en && APB_REQ.pwdata[PCG_CORE_BIT]) begin
               core_state_d = PCG_CORE_RUN;
            end else if (CORE_IN.instr_done) begin
               core_state_d = PCG_CORE_HALTED;
            end
         end
         PCG_CORE_HALTED: begin
            if (CORE_IN.irq_pending) begin
               core_state_d = PCG_CORE_RUN;
            end else if (wr_sys_en && APB_REQ.pwdata[PCG_CORE_BIT]) begin
               core_state_d = PCG_CORE_RUN;
            end
         end
         default: begin
            core_state_d = PCG_CORE_RUN;
         end
      endcase
   end

   assign core_on_d = core_state_d != PCG_CORE_HALTED;

   // The core starts running out of reset.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         core_state_q <= PCG_CORE_RUN;
         core_on_q <= PCG_SYS_STATE_RST[PCG_CORE_BIT];
      end else begin
         core_state_q <= core_state_d;
         core_on_q <= core_on_d;
      end
   end

   // Peripheral gates. Enable and disable writes never fall in the same
   // cycle, so the order of set and clear here is immaterial. The new
   // state takes effect on the very next clock edge with no hand-shake
   // to the peripheral, which is why software must drain it first.
   assign per_on_d = (per_on_q | per_set) & ~per_clr;

   // All peripheral gates start closed.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         per_on_q <= PCG_PER_STATE_RST[PCG_GATE_W-1:0];
      end else begin
         per_on_q <= per_on_d;
      end
   end

   // State outputs for the rest of the chip, straight from flip-flops.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CORE_CLK_ON <= PCG_SYS_STATE_RST[PCG_CORE_BIT];
         CORE_STOP_PENDING <= 1'b0;
         PERIPH_CLK_ON <= PCG_PER_STATE_RST[PCG_GATE_W-1:0];
      end else begin
         CORE_CLK_ON <= core_on_d;
         CORE_STOP_PENDING <= core_state_d == PCG_CORE_STOPPING;
         PERIPH_CLK_ON <= per_on_d & PER_MASK;
      end
   end

   // The core gate is driven by the core state alone. The DMA channels
   // sit on the peripheral gates and on CLK, so halting the core never
   // holds up their transfers.
   pcg_clk_gate u_core_gate (
      .clk_in(CLK),
      .clk_out(CORE_CLK),
      .en(core_on_q)
   );

   // One gate per peripheral at its interrupt source position. Closing
   // a gate only stops the clock: no reset reaches the peripheral, so
   // it resumes from the state it held.
   for (genvar i = 0; i < PCG_GATE_W; i++) begin : g_per
      if (PER_MASK[i]) begin : g_gate
         pcg_clk_gate u_gate (
            .clk_in(CLK),
            .clk_out(PERIPH_CLK[i]),
            .en(per_on_q[i])
         );
      end else begin : g_none
         assign PERIPH_CLK[i] = 1'b0;
      end
   end

endmodule

// [core/pcg_pkg.sv]
/*
 * Shared constants and types of the core and peripheral clock gating block:
 * register byte offsets, gate bit positions, reset values and the packed
 * carriers of the register bus and of the processor core handshake.
 * Assumes a 32-bit APB with an 8-bit byte address local to this block.
 */
package pcg_pkg;

   // Bus geometry.
   localparam int PCG_ADDR_W = 8;
   localparam int PCG_DATA_W = 32;

   // Register byte offsets.
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_SYS_EN = 8'h00;
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_SYS_DIS = 8'h04;
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_SYS_STATE = 8'h08;
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_PER_EN = 8'h10;
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_PER_DIS = 8'h14;
   localparam logic [PCG_ADDR_W-1:0] PCG_OFS_PER_STATE = 8'h18;

   // Field positions.
   localparam int PCG_CORE_BIT = 0;
   localparam int PCG_GATE_W = 15;
   localparam int PCG_SERIAL_PORT_0_GATE = 2;
   localparam int PCG_SERIAL_PORT_1_GATE = 3;
   localparam int PCG_SERIAL_PORT_2_GATE = 4;
   localparam int PCG_SPI_GATE = 5;
   localparam int PCG_TIMER_CHANNEL_0_GATE = 6;
   localparam int PCG_TIMER_CHANNEL_5_GATE = 11;
   localparam int PCG_PARALLEL_PORT_A_GATE = 13;
   localparam int PCG_PARALLEL_PORT_B_GATE = 14;

   // Gate bits that exist: serial ports, SPI, timers, parallel ports.
   localparam logic [PCG_GATE_W-1:0] PCG_PER_MASK = 15'h6ffc;

   // Reset values of the status registers.
   localparam logic [PCG_DATA_W-1:0] PCG_SYS_STATE_RST = 32'h0000_0001;
   localparam logic [PCG_DATA_W-1:0] PCG_PER_STATE_RST = 32'h0000_0000;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [PCG_ADDR_W-1:0] paddr;
      logic [PCG_DATA_W-1:0] pwdata;
   } pcg_apb_req_t;

   typedef struct packed {
      logic [PCG_DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } pcg_apb_rsp_t;

   // Handshake from the core and the interrupt controller, same clock.
   typedef struct packed {
      logic instr_done;
      logic irq_pending;
   } pcg_core_in_t;

   typedef enum logic [1:0] {
      PCG_CORE_RUN,
      PCG_CORE_STOPPING,
      PCG_CORE_HALTED
   } pcg_core_state_t;

endpackage
